// >>> hw/serial_port.sv
// Purpose: Asynchronous serial transmitter and receiver with queues.
// Assumes: AHB-Lite single word transfers; source ticks synchronous.
// Notes: Zero-wait slave; response always OKAY.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module serial_port
   import serial_pkg::*;
(
   input wire logic ref_clk, // 40 MHz core clock
   input wire logic reset, // Async reset, active high
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic [31:0] hrdata, // AHB read data
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response
   input wire logic src24_tick, // 24 MHz source clock pulse
   input wire logic src16_tick, // 16 MHz source clock pulse
   input wire logic rxd, // Serial input
   output logic txd, // Serial output
   output logic irq // Interrupt request, active high
);
   // Bus state
   logic dp_wr_r;
   logic [7:0] dp_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   // Control registers
   logic [7:0] lcr_r;
   logic [3:0] ier_r;
   logic [15:0] div_r;
   logic fifo_en_r;
   logic [1:0] trig_r;
   logic clksel_r;
   logic [7:0] scr_r;
   // Baud generator
   logic [15:0] bcnt_r;
   logic tick_r;
   // Transmit
   tx_state_t tx_st_r;
   logic txd_r;
   logic [7:0] tsh_r;
   logic tpar_r;
   logic [4:0] tcnt_r;
   logic [2:0] tidx_r;
   // Receive
   rx_state_t rx_st_r;
   logic [7:0] rsh_r;
   logic [4:0] rcnt_r;
   logic [2:0] ridx_r;
   logic rpar_bad_r;
   // Status and interrupts
   logic oe_r, pe_r, fe_r, bi_r, to_r, thre_r, tx_empty_d_r, irq_r;
   logic [9:0] tocnt_r;

   // Address phase decode; hsize is always a word here
   wire ap = hsel & htrans[1] & hready;
   wire ap_rd = ap & ~hwrite;
   wire [7:0] ra = haddr[7:0];
   wire dlab = lcr_r[LCR_DLAB];
   wire wr_data = dp_wr_r & (dp_addr_r == OFS_DATA) & ~dlab;
   wire wr_dll = dp_wr_r & (dp_addr_r == OFS_DATA) & dlab;
   wire wr_ier = dp_wr_r & (dp_addr_r == OFS_IER) & ~dlab;
   wire wr_dlm = dp_wr_r & (dp_addr_r == OFS_IER) & dlab;
   wire wr_fcr = dp_wr_r & (dp_addr_r == OFS_IIR);
   wire rd_rbr = ap_rd & (ra == OFS_DATA) & ~dlab;
   wire rd_iir = ap_rd & (ra == OFS_IIR);
   wire rd_lsr = ap_rd & (ra == OFS_LSR);
   wire [7:0] wd = hwdata[7:0];

   // Queues; without FIFO mode each holds a single byte
   wire [7:0] tx_dout, rx_dout;
   wire [4:0] tx_count, rx_count;
   wire tx_empty = (tx_count == 5'h00);
   wire rx_empty = (rx_count == 5'h00);
   wire tx_full = fifo_en_r ? (tx_count == 5'h10) : ~tx_empty;
   wire rx_full = fifo_en_r ? (rx_count == 5'h10) : ~rx_empty;
   wire fifo_chg = wr_fcr & (wd[FCR_EN] != fifo_en_r);
   wire tx_flush = wr_fcr & (wd[FCR_TXCLR] | fifo_chg);
   wire rx_flush = wr_fcr & (wd[FCR_RXCLR] | fifo_chg);
   wire tx_push = wr_data & ~tx_full;
   wire tx_pop = (tx_st_r == TX_IDLE) & ~tx_empty;
   wire rx_push;
   wire [7:0] rx_word;
   wire rx_pop = rd_rbr & ~rx_empty;

   byte_fifo u_tx_fifo (
      .ref_clk(ref_clk), .reset(reset), .flush(tx_flush),
      .push(tx_push), .din(wd), .pop(tx_pop),
      .dout(tx_dout), .count(tx_count)
   );
   byte_fifo u_rx_fifo (
      .ref_clk(ref_clk), .reset(reset), .flush(rx_flush),
      .push(rx_push & ~rx_full), .din(rx_word), .pop(rx_pop),
      .dout(rx_dout), .count(rx_count)
   );

   // Character format decode
   wire [1:0] wl = lcr_r[1:0];
   wire [2:0] last_idx = 3'h4 + {1'b0, wl};
   wire [7:0] wl_mask = 8'hFF >> (2'h3 - wl);
   wire pen = lcr_r[LCR_PEN];
   wire eps = lcr_r[LCR_EPS];
   wire stick = lcr_r[LCR_STICK];
   // parity select
   // Sticky parity forces the bit to the inverse of the even select
   wire [7:0] tmask = tx_dout & wl_mask;
   wire tx_par = stick ? ~eps : (eps ? ^tmask : ~^tmask);
   // stop length
   // One and a half stops only for five-bit characters
   wire [4:0] stop_last = ~lcr_r[LCR_STB] ? BIT_LAST :
      (wl == 2'h0) ? STOP15_LAST : STOP2_LAST;

   // source select, rates set by divisor
   // divisor, zero is taken as one
   wire src_tick = clksel_r ? src16_tick : src24_tick;
   wire [15:0] div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
   wire bdone = bcnt_r >= (div_eff - 16'h0001);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bcnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= src_tick & bdone;
         if (src_tick) begin
            bcnt_r <= bdone ? 16'h0000 : bcnt_r + 16'h0001;
         end
      end
   end

   // Control register writes
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lcr_r <= LCR_RST;
         ier_r <= IER_RST;
         div_r <= DIV_RST;
         fifo_en_r <= 1'b0;
         trig_r <= 2'h0;
         clksel_r <= 1'b0;
         scr_r <= 8'h00;
      end else if (dp_wr_r) begin
         if (dp_addr_r == OFS_LCR) lcr_r <= wd;
         if (wr_ier) ier_r <= wd[3:0];
         if (wr_dll) div_r[7:0] <= wd;
         if (wr_dlm) div_r[15:8] <= wd;
         if (wr_fcr) fifo_en_r <= wd[FCR_EN];
         if (wr_fcr) trig_r <= wd[7:6];
         if (dp_addr_r == OFS_CLK) clksel_r <= wd[0];
         if (dp_addr_r == OFS_SCR) scr_r <= wd;
      end
   end

   wire tbit = tick_r & (tcnt_r == BIT_LAST);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_st_r <= TX_IDLE;
         txd_r <= 1'b1;
         tsh_r <= 8'h00;
         tpar_r <= 1'b0;
         tcnt_r <= 5'h00;
         tidx_r <= 3'h0;
      end else begin
         if (tick_r) tcnt_r <= tcnt_r + 5'h01;
         case (tx_st_r)
            TX_IDLE: begin
               txd_r <= 1'b1;
               if (tx_pop) begin
                  tsh_r <= tx_dout;
                  tpar_r <= tx_par;
                  tx_st_r <= TX_START;
                  txd_r <= 1'b0;
                  tcnt_r <= 5'h00;
               end
            end
            TX_START: if (tbit) begin
               tx_st_r <= TX_DATA;
               tcnt_r <= 5'h00;
               tidx_r <= 3'h0;
               txd_r <= tsh_r[0];
            end
            TX_DATA: if (tbit) begin
               tcnt_r <= 5'h00;
               tidx_r <= tidx_r + 3'h1;
               tsh_r <= tsh_r >> 1;
               txd_r <= tsh_r[1];
               if (tidx_r == last_idx) begin
                  tx_st_r <= pen ? TX_PAR : TX_STOP;
                  txd_r <= pen ? tpar_r : 1'b1;
               end
            end
            TX_PAR: if (tbit) begin
               tx_st_r <= TX_STOP;
               tcnt_r <= 5'h00;
               txd_r <= 1'b1;
            end
            TX_STOP: if (tick_r && tcnt_r >= stop_last) begin
               tx_st_r <= TX_IDLE;
               txd_r <= 1'b1;
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // receive on 16x ticks through the filter
   wire rxf;
   rx_filter u_rx_filter (
      .ref_clk(ref_clk), .reset(reset), .tick(tick_r),
      .din(rxd), .dout(rxf)
   );

   // first bit lands in bit 0 after alignment
   assign rx_word = rsh_r >> (2'h3 - wl);
   wire rx_exp = stick ? ~eps : (eps ? ^rx_word : ~^rx_word);
   wire rbit = tick_r & (rcnt_r == BIT_LAST);
   wire rx_stop_hit = (rx_st_r == RX_STOP) & rbit;
   assign rx_push = rx_stop_hit;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rx_st_r <= RX_IDLE;
         rsh_r <= 8'h00;
         rcnt_r <= 5'h00;
         ridx_r <= 3'h0;
         rpar_bad_r <= 1'b0;
      end else begin
         if (tick_r) rcnt_r <= rcnt_r + 5'h01;
         case (rx_st_r)
            RX_IDLE: if (tick_r && !rxf) begin
               rx_st_r <= RX_START;
               rcnt_r <= 5'h00;
               rsh_r <= 8'h00;
               rpar_bad_r <= 1'b0;
            end
            RX_START: if (tick_r && rcnt_r == HALF_BIT) begin
               rx_st_r <= rxf ? RX_IDLE : RX_DATA;
               rcnt_r <= 5'h00;
               ridx_r <= 3'h0;
            end
            RX_DATA: if (rbit) begin
               rcnt_r <= 5'h00;
               rsh_r <= {rxf, rsh_r[7:1]};
               ridx_r <= ridx_r + 3'h1;
               if (ridx_r == last_idx) rx_st_r <= pen ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rbit) begin
               rcnt_r <= 5'h00;
               rpar_bad_r <= (rxf != rx_exp);
               rx_st_r <= RX_STOP;
            end
            RX_STOP: if (rbit) rx_st_r <= RX_IDLE;
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   // sticky line errors; a new error beats the clearing read
   wire set_fe = rx_stop_hit & ~rxf;
   wire set_bi = set_fe & (rsh_r == 8'h00);
   wire set_oe = rx_push & rx_full;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         oe_r <= 1'b0;
         pe_r <= 1'b0;
         fe_r <= 1'b0;
         bi_r <= 1'b0;
      end else begin
         oe_r <= set_oe | (oe_r & ~rd_lsr);
         pe_r <= (rx_stop_hit & rpar_bad_r) | (pe_r & ~rd_lsr);
         fe_r <= set_fe | (fe_r & ~rd_lsr);
         bi_r <= set_bi | (bi_r & ~rd_lsr);
      end
   end

   // character timeout; only meaningful with queues on
   wire to_hold = ~fifo_en_r | rx_empty | rx_push | rx_pop;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tocnt_r <= 10'h000;
         to_r <= 1'b0;
      end else begin
         if (to_hold) tocnt_r <= 10'h000;
         else if (tick_r && !to_r) tocnt_r <= tocnt_r + 10'h001;
         to_r <= ~to_hold & (to_r | (tocnt_r == TIMEOUT_TICKS));
      end
   end

   wire [4:0] trig_lvl = (trig_r == 2'h0) ? TRIG_1 : (trig_r == 2'h1) ?
      TRIG_4 : (trig_r == 2'h2) ? TRIG_8 : TRIG_14;
   wire rx_avail = fifo_en_r ? (rx_count >= trig_lvl) : ~rx_empty;
   wire ls_err = oe_r | pe_r | fe_r | bi_r;
   wire [3:0] iir_code = (ier_r[2] & ls_err) ? IIR_LS :
      (ier_r[0] & rx_avail) ? IIR_RDA :
      (ier_r[0] & to_r) ? IIR_TMO :
      (ier_r[1] & thre_r) ? IIR_THRE : IIR_NONE;

   // transmit-empty event; set wins over the clearing access
   wire thre_set = (tx_empty & ~tx_empty_d_r) |
      (wr_ier & wd[1] & ~ier_r[1] & tx_empty);
   wire thre_clr = tx_push | (rd_iir & (iir_code == IIR_THRE));
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_empty_d_r <= 1'b1;
         thre_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         tx_empty_d_r <= tx_empty;
         thre_r <= thre_set | (thre_r & ~thre_clr);
         irq_r <= (iir_code != IIR_NONE);
      end
   end

   // Read mux; unmapped addresses read zero
   wire tx_busy = (tx_st_r != TX_IDLE);
   wire [7:0] lsr = {ls_err, tx_empty & ~tx_busy, tx_empty,
      bi_r, fe_r, pe_r, oe_r, ~rx_empty};
   wire [7:0] rmux = (ra == OFS_DATA) ? (dlab ? div_r[7:0] : rx_dout) :
      (ra == OFS_IER) ? (dlab ? div_r[15:8] : {4'h0, ier_r}) :
      (ra == OFS_IIR) ? {{2{fifo_en_r}}, 2'h0, iir_code} :
      (ra == OFS_LCR) ? lcr_r : (ra == OFS_LSR) ? lsr :
      (ra == OFS_SCR) ? scr_r : (ra == OFS_CLK) ? {7'h00, clksel_r} :
      8'h00;

   // Bus slave: capture address phase, answer with no wait states
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         dp_wr_r <= ap & hwrite;
         dp_addr_r <= ra;
         hrdata_r <= ap_rd ? {24'h000000, rmux} : 32'h00000000;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign txd = txd_r;
   assign irq = irq_r;

   AST_TX_IDLE_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
      (tx_st_r == TX_IDLE) |-> txd_r)
      else $error("line not high while idle");
   AST_START_LOW: assert property (@(posedge ref_clk) disable iff (reset)
      (tx_st_r == TX_START) |-> !txd_r)
      else $error("start bit not low");
   AST_STOP_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
      (tx_st_r == TX_STOP) |-> txd_r)
      else $error("stop bit not high");
   AST_TX_LAUNCH: assert property (@(posedge ref_clk) disable iff (reset)
      (tx_st_r == TX_IDLE && !tx_empty) |=> tx_st_r == TX_START)
      else $error("queued byte not launched");
   AST_RX_HOLD_ONE: assert property (@(posedge ref_clk) disable iff (reset)
      !fifo_en_r |-> rx_count <= 5'h01)
      else $error("buffer holds more than one byte");
   AST_LS_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
      (ier_r[2] && ls_err) |-> iir_code == IIR_LS)
      else $error("line status not reported first");
   AST_RDA_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
      (ier_r[0] && rx_avail && !(ier_r[2] && ls_err)) |=> irq_r)
      else $error("data interrupt missing");
   AST_PAR_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
      (rx_stop_hit && rpar_bad_r) |=> pe_r)
      else $error("parity error not flagged");
   AST_TICK_GAP: assert property (@(posedge ref_clk) disable iff (reset)
      (tick_r && div_r > 16'h0001) |=> !tick_r)
      else $error("baud ticks too close");
endmodule : serial_port

// >>> hw/serial_pkg.sv
// Purpose: Shared constants and types for the asynchronous serial port.
// Assumes: One 40 MHz clock, word-aligned AHB-Lite register map.
// Notes: Offsets are byte addresses; every register sits in one word.
package serial_pkg;
   // Data path and queue shape
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned FIFO_AW = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_IER = 8'h04;
   localparam logic [7:0] OFS_IIR = 8'h08;
   localparam logic [7:0] OFS_LCR = 8'h0C;
   localparam logic [7:0] OFS_LSR = 8'h14;
   localparam logic [7:0] OFS_SCR = 8'h1C;
   localparam logic [7:0] OFS_CLK = 8'h20;
   // Values after reset
   localparam logic [7:0] LCR_RST = 8'h03;
   localparam logic [3:0] IER_RST = 4'h0;
   localparam logic [15:0] DIV_RST = 16'h0001;
   // Character format field positions
   localparam int unsigned LCR_STB = 2;
   localparam int unsigned LCR_PEN = 3;
   localparam int unsigned LCR_EPS = 4;
   localparam int unsigned LCR_STICK = 5;
   localparam int unsigned LCR_DLAB = 7;
   // FIFO control field positions
   localparam int unsigned FCR_EN = 0;
   localparam int unsigned FCR_RXCLR = 1;
   localparam int unsigned FCR_TXCLR = 2;
   // Interrupt identity codes, highest priority first
   localparam logic [3:0] IIR_LS = 4'h6;
   localparam logic [3:0] IIR_RDA = 4'h4;
   localparam logic [3:0] IIR_TMO = 4'hC;
   localparam logic [3:0] IIR_THRE = 4'h2;
   localparam logic [3:0] IIR_NONE = 4'h1;
   // Receive trigger levels in stored bytes
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0E;
   // Bit timing in 16x ticks
   localparam logic [4:0] BIT_LAST = 5'h0F;
   localparam logic [4:0] HALF_BIT = 5'h07;
   localparam logic [4:0] STOP15_LAST = 5'h17;
   localparam logic [4:0] STOP2_LAST = 5'h1F;
   // Character timeout: four ten-bit characters of 16x ticks
   localparam logic [9:0] TIMEOUT_TICKS = 10'h280;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      rx_state_t;
endpackage : serial_pkg

// >>> hw/byte_fifo.sv
// Purpose: Sixteen-entry byte queue in flip-flops.
// Assumes: Caller never pushes when full nor pops when empty.
// Notes: Flush wins over push and pop in the same cycle.
`timescale 1ns/10ps
module byte_fifo
   import serial_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic reset, // Async reset, active high
   input wire logic flush, // Empty the queue
   input wire logic push, // Write one byte
   input wire logic [7:0] din, // Byte to write
   input wire logic pop, // Drop the head byte
   output logic [7:0] dout, // Head byte
   output logic [4:0] count // Bytes stored
);
   logic [7:0] mem_r [FIFO_DEPTH];
   logic [3:0] wp_r;
   logic [3:0] rp_r;
   logic [4:0] cnt_r;

   // Head and fill
   assign dout = mem_r[rp_r];
   assign count = cnt_r;

   // Pointers and fill count
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wp_r <= 4'h0;
         rp_r <= 4'h0;
         cnt_r <= 5'h00;
      end else if (flush) begin
         wp_r <= 4'h0;
         rp_r <= 4'h0;
         cnt_r <= 5'h00;
      end else begin
         wp_r <= wp_r + {3'h0, push};
         rp_r <= rp_r + {3'h0, pop};
         cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop};
      end
   end

   // Storage, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wp_r] <= din;
      end
   end
endmodule : byte_fifo

// >>> hw/rx_filter.sv
// Purpose: Glitch filter on the serial input, sampled on 16x ticks.
// Assumes: Input is synchronous to ref_clk.
// Notes: Output follows only after two agreeing tick samples.
`timescale 1ns/10ps
module rx_filter
   import serial_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic reset, // Async reset, active high
   input wire logic tick, // 16x receive clock enable
   input wire logic din, // Raw serial input
   output logic dout // Filtered line level
);
   logic s0_r;
   logic s1_r;
   logic out_r;

   assign dout = out_r;

   // two-tick filter
   // A pulse no longer than one tick period is seen by at most one sample
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s0_r <= 1'b1;
         s1_r <= 1'b1;
         out_r <= 1'b1;
      end else if (tick) begin
         s0_r <= din;
         s1_r <= s0_r;
         if (s0_r == s1_r) begin
            out_r <= s0_r;
         end
      end
   end

   AST_FILTER_AGREE: assert property (@(posedge ref_clk) disable iff (reset)
      (out_r != $past(out_r)) |-> $past(s0_r) == $past(s1_r))
      else $error("filter output moved without two samples");
endmodule : rx_filter

// >>> testbench/remote_serial.sv
// Purpose: Remote serial device on the far side of the link.
// Assumes: Bit period fixed in core clock cycles.
// Notes: Samples mid-bit; line idles high between characters.
`timescale 1ns/10ps
module remote_serial #(
   parameter int BIT = 96
) (
   input wire logic clk, // Core clock
   input wire logic txd_i, // Line from the port
   output logic rxd_o // Line into the port
);
   initial rxd_o = 1'b1;
   // One bit for a full period
   task automatic put(input logic v);
      rxd_o <= v;
      repeat (BIT) @(posedge clk);
   endtask : put
   task automatic send_char(input logic [7:0] d, input int par,
      input logic stp);
      @(posedge clk);
      put(1'b0);
      for (int i = 0; i < 8; i++) put(d[i]);
      if (par >= 0) put(par[0]);
      put(stp);
      put(1'b1);
   endtask : send_char
   // Short low pulse the filter must drop
   task automatic pulse(input int n);
      @(posedge clk);
      rxd_o <= 1'b0;
      repeat (n) @(posedge clk);
      rxd_o <= 1'b1;
   endtask : pulse
   // mid-bit sampling; bit 8 is the one after the data
   task automatic get_char(output logic [8:0] d);
      int n;
      d = 'x;
      n = 0;
      while (txd_i !== 1'b0 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n < 40000) begin
         repeat (BIT / 2) @(posedge clk);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = txd_i;
         end
         // Skip a low parity bit, else it looks like a new start
         for (n = 0; n < BIT && txd_i !== 1'b1; n++) @(posedge clk);
      end
   endtask : get_char
endmodule : remote_serial

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the serial port.
// Assumes: Divisor 2 on a 40/3 MHz tick, so 96 cycles a bit.
// Notes: Zero-wait bus; hready follows hreadyout.
`timescale 1ns/10ps
module tb_top;
   import serial_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
   logic [1:0] htrans = '0, tc = '0;
   logic src24_tick = 1'b0, src16_tick = 1'b0;
   logic hreadyout, hresp, txd, irq, rxd;
   logic [8:0] ch;
   int failures = 0, checks_done = 0;
   typedef struct packed {logic [7:0] lcr; logic [8:0] exp;} row_t;
   // Every parity mode on 0x5A, four ones; last row six bits, odd, 2 stops
   row_t rows [6] = '{'{8'h03, 9'h15A}, '{8'h1B, 9'h05A},
      '{8'h0B, 9'h15A}, '{8'h2B, 9'h15A}, '{8'h3B, 9'h05A},
      '{8'h0D, 9'h19A}};
   always #12.5 ref_clk = ~ref_clk;
   // Source ticks as enables
   always @(posedge ref_clk) begin
      tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
      src16_tick <= (tc == 2'h0);
      src24_tick <= ~src24_tick;
   end
   serial_port dut_u(.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .src24_tick, .src16_tick, .rxd, .txd, .irq);
   remote_serial #(.BIT(96)) peer_u(.clk(ref_clk), .txd_i(txd),
      .rxd_o(rxd));
   task automatic end_sim();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait for hready seen high at an edge
   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("hready", 1, 0);
         end_sim();
      end
   endtask : wait_rdy
   // One single AHB transfer, entered and left at a rising edge
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      rv = hrdata;
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e, input string nm);
      bus(a, 1'b0, 8'h00);
      chk(nm, {24'h0, e}, rv & {24'h0, m});
   endtask : rdc
   // Hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      chk("run length", 0, 1);
      end_sim();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("txd idle", 1, 32'(txd));
      chk("irq idle", 0, 32'(irq));
      chk("hresp", 0, 32'(hresp));
      rdc(OFS_LCR, 8'hFF, LCR_RST, "lcr reset");
      rdc(OFS_IIR, 8'hFF, 8'h01, "iir reset");
      rdc(OFS_LSR, 8'hFF, 8'h60, "lsr reset");
      rdc(8'h10, 8'hFF, 8'h00, "unmapped");
      bus(OFS_SCR, 1'b1, 8'hA5);
      rdc(OFS_SCR, 8'hFF, 8'hA5, "scratch");
      $display("test reset done");
      // divisor 2 on the 40/3 MHz tick
      bus(OFS_LCR, 1'b1, 8'h83);
      bus(OFS_DATA, 1'b1, 8'h02);
      bus(OFS_IER, 1'b1, 8'h00);
      bus(OFS_CLK, 1'b1, 8'h01);
      foreach (rows[i]) begin
         bus(OFS_LCR, 1'b1, rows[i].lcr);
         bus(OFS_DATA, 1'b1, 8'h5A);
         peer_u.get_char(ch);
         chk("tx char", 32'(rows[i].exp), 32'(ch));
      end
      $display("test formats done");
      bus(OFS_LCR, 1'b1, 8'h03);
      peer_u.send_char(8'hC3, -1, 1'b1);
      rdc(OFS_DATA, 8'hFF, 8'hC3, "rx data");
      bus(OFS_LCR, 1'b1, 8'h1B);
      peer_u.send_char(8'h5A, 1, 1'b1);
      rdc(OFS_LSR, 8'h0F, 8'h05, "lsr parity");
      rdc(OFS_DATA, 8'hFF, 8'h5A, "rx parity data");
      bus(OFS_LCR, 1'b1, 8'h03);
      peer_u.send_char(8'h0F, -1, 1'b0);
      rdc(OFS_LSR, 8'h0F, 8'h09, "lsr framing");
      rdc(OFS_DATA, 8'hFF, 8'h0F, "rx framing data");
      peer_u.pulse(6);
      repeat (2000) @(posedge ref_clk);
      rdc(OFS_LSR, 8'h01, 8'h00, "glitch dropped");
      $display("test receive done");
      // Queues on, trigger at four bytes
      bus(OFS_IIR, 1'b1, 8'h41);
      bus(OFS_IER, 1'b1, 8'h01);
      for (int i = 0; i < 4; i++) begin
         chk("irq below trigger", 0, 32'(irq));
         peer_u.send_char(8'h10 + 8'(i), -1, 1'b1);
      end
      chk("irq at trigger", 1, 32'(irq));
      rdc(OFS_IIR, 8'hFF, 8'hC4, "iir rx data");
      for (int i = 0; i < 4; i++)
         rdc(OFS_DATA, 8'hFF, 8'h10 + 8'(i), "rx queue");
      repeat (2) @(posedge ref_clk);
      chk("irq drained", 0, 32'(irq));
      $display("test rx queue done");
      // Transmit queue drains fully, then reports empty
      bus(OFS_IER, 1'b1, 8'h02);
      for (int i = 0; i < 3; i++) bus(OFS_DATA, 1'b1, 8'h31 + 8'(i));
      for (int i = 0; i < 3; i++) begin
         peer_u.get_char(ch);
         chk("tx queue", 32'h131 + i, 32'(ch));
      end
      chk("irq tx empty", 1, 32'(irq));
      rdc(OFS_IIR, 8'hFF, 8'hC2, "iir tx empty");
      repeat (2) @(posedge ref_clk);
      chk("irq after iir read", 0, 32'(irq));
      // Receive data outranks transmit empty; trigger back to one byte,
      // and enabling the empty source again raises it while idle
      bus(OFS_IIR, 1'b1, 8'h01);
      bus(OFS_IER, 1'b1, 8'h00);
      bus(OFS_IER, 1'b1, 8'h03);
      peer_u.send_char(8'h77, -1, 1'b1);
      rdc(OFS_IIR, 8'hFF, 8'hC4, "iir priority");
      rdc(OFS_DATA, 8'hFF, 8'h77, "rx last");
      rdc(OFS_IIR, 8'hFF, 8'hC2, "iir next cause");
      $display("test queues done");
      // A lone byte under the trigger level is reported by the timeout
      bus(OFS_IIR, 1'b1, 8'h41);
      peer_u.send_char(8'h66, -1, 1'b1);
      repeat (4000) @(posedge ref_clk);
      rdc(OFS_IIR, 8'hFF, 8'hCC, "iir timeout");
      rdc(OFS_DATA, 8'hFF, 8'h66, "rx timeout data");
      // Other source: divisor 3 on the 20 MHz tick keeps 96 cycles a bit
      bus(OFS_LCR, 1'b1, 8'h83);
      bus(OFS_DATA, 1'b1, 8'h03);
      bus(OFS_LCR, 1'b1, 8'h03);
      bus(OFS_CLK, 1'b1, 8'h00);
      bus(OFS_DATA, 1'b1, 8'hA6);
      peer_u.get_char(ch);
      chk("tx other source", 32'h1A6, 32'(ch));
      $display("test sources done");
      end_sim();
   end
endmodule : tb_top
